/* shared/lane_steer_pkg.sv */
package lane_steer_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int unsigned DATA_W = 64;
  localparam int unsigned OFF_W = 3;
  localparam int unsigned SIZE_W = 3;
  localparam int unsigned ELSIZE_W = 2;
  localparam logic [3:0] LANE_COUNT = 4'h8;

  // Transfer size codes; a code is the byte count modulo eight
  localparam logic [2:0] SIZE_DWORD = 3'h0;
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_HALF = 3'h2;
  localparam logic [2:0] SIZE_WORD = 3'h4;

  // ----------------------------------------
  // Sequencer states, Gray along the path
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FIRST = 2'h1,
    ST_SECOND = 2'h3
  } xfer_state_e;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned REG_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SPLITS = 8'h08;
  localparam logic [7:0] ADDR_ACCESSES = 8'h0c;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_SECOND_BIT = 1;
  localparam int unsigned STAT_RDLE_BIT = 2;
  localparam int unsigned STAT_WRLE_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] size_bytes(input logic [2:0] code);
    size_bytes = (code == SIZE_DWORD) ? LANE_COUNT : {1'b0, code};
  endfunction : size_bytes

  function automatic logic [6:0] lane_bits(input logic [3:0] count);
    lane_bits = {count, 3'h0};
  endfunction : lane_bits

  function automatic logic [63:0] byte_rev(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
    begin
      byte_rev[8*i +: 8] = v[8*(7-i) +: 8];
    end
  endfunction : byte_rev

endpackage : lane_steer_pkg

/* design/lane_steer.sv */
`timescale 1ns/1ps
// What this block does
// - A read moves one to eight bytes; lanes follow offset and size code.
// - Read lanes are always big-endian: offset zero on B0, offset seven on B7.
// - Returned read bytes are reordered per read endian select at data return.
// - An access crossing a doubleword is split; second one starts next doubleword.
// - The first transfer of a split keeps the original size code.
// - Halfword at offset 7: size 010 there, then size 001 at offset 0.
// - Word read at offset 5: lanes B5-B7, then size 001 on B0.
// - Doubleword at nonzero offset splits; second size equals bytes left.
// - Unused lanes are driven but meaningless; nobody relies on them.
// - Write data goes right-justified, ordered by the write endian select.
// - Both halves of a split write show identical write data.
// - Word write uses B4-B7; at offset 7 sizes 100 then 011.
// - Each store carries a two-bit element size qualifier.
// - Big-endian halfword store at 7 is a halfword then a byte transfer.
module lane_steer #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [lane_steer_pkg::SIZE_W-1:0] req_size,
  input wire logic [lane_steer_pkg::ELSIZE_W-1:0] req_elsize,
  input wire logic [lane_steer_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [lane_steer_pkg::DATA_W-1:0] rsp_rdata,
  output logic bus_valid,
  output logic bus_write,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [lane_steer_pkg::SIZE_W-1:0] transfer_size_code,
  output logic [lane_steer_pkg::ELSIZE_W-1:0] bus_elsize,
  output logic [lane_steer_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_done,
  input wire logic [lane_steer_pkg::DATA_W-1:0] bus_rdata,
  input wire logic rd_little_endian,
  input wire logic wr_little_endian,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lane_steer_pkg::REG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [lane_steer_pkg::REG_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import lane_steer_pkg::*;

  // Offset field plus a doubleword index is the least address we can serve
  if (ADDR_W < 4)
  begin : g_bad_width
    $error("lane_steer: ADDR_W must be at least 4");
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  xfer_state_e state_reg, state_next;
  logic req_ready_reg, req_ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [63:0] rsp_rdata_reg, rsp_rdata_next;
  logic bus_valid_reg, bus_valid_next;
  logic bus_write_reg, bus_write_next;
  logic [ADDR_W-1:0] bus_addr_reg, bus_addr_next;
  logic [2:0] bus_size_reg, bus_size_next;
  logic [1:0] bus_elsize_reg, bus_elsize_next;
  logic [63:0] bus_wdata_reg, bus_wdata_next;
  logic [2:0] off_reg, off_next;
  logic [3:0] n_reg, n_next;
  logic split_reg, split_next;
  logic [63:0] acc_reg, acc_next;
  logic rd_le_reg, rd_le_next;
  logic ctrl_enable_reg, ctrl_enable_next;
  logic [31:0] splits_reg, splits_next;
  logic [31:0] accesses_reg, accesses_next;
  logic take;
  logic [3:0] req_n;
  logic [3:0] rem;
  logic [63:0] gathered;
  logic [63:0] ordered;
  logic [7:0] lane_byte;
  logic cnt_clr_splits, cnt_clr_acc;

  assign take = req_valid && req_ready_reg;
  assign req_n = size_bytes(req_size);
  // Bytes left for the next doubleword; only meaningful when split
  assign rem = 4'({1'b0, off_reg} + n_reg - LANE_COUNT);
  // Diagnostic tap: the lane that carries the first byte
  assign lane_byte = bus_rdata[8*(7-off_reg) +: 8];

  // Gather memory bytes so the first one sits in the top lane
  always_comb
  begin
    if (state_reg == ST_SECOND)
    begin
      gathered = acc_reg | (bus_rdata >> (7'd64 - lane_bits({1'b0, off_reg})));
    end
    else
    begin
      gathered = bus_rdata << lane_bits({1'b0, off_reg});
    end
    if (rd_little_endian)
    begin
      ordered = byte_rev(gathered) & ~({64{1'b1}} << lane_bits(n_reg));
    end
    else
    begin
      ordered = gathered >> (7'd64 - lane_bits(n_reg));
    end
  end

  // Next state of the sequencer and the bus request it drives
  always_comb
  begin
    state_next = state_reg;
    rsp_valid_next = 1'b0;
    rsp_rdata_next = rsp_rdata_reg;
    bus_valid_next = bus_valid_reg;
    bus_write_next = bus_write_reg;
    bus_addr_next = bus_addr_reg;
    bus_size_next = bus_size_reg;
    bus_elsize_next = bus_elsize_reg;
    bus_wdata_next = bus_wdata_reg;
    off_next = off_reg;
    n_next = n_reg;
    split_next = split_reg;
    acc_next = acc_reg;
    rd_le_next = rd_le_reg;
    splits_next = cnt_clr_splits ? 32'h0 : splits_reg;
    accesses_next = cnt_clr_acc ? 32'h0 : accesses_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take)
        begin
          state_next = ST_FIRST;
          bus_valid_next = 1'b1;
          bus_write_next = req_write;
          bus_addr_next = req_addr;
          bus_size_next = req_size;
          bus_elsize_next = req_elsize;
          // Big-endian keeps whatever the core left in unused upper lanes; little-endian zeroes them
          if (wr_little_endian)
          begin
            bus_wdata_next = byte_rev(req_wdata) >> (7'd64 - lane_bits(req_n));
          end
          else
          begin
            bus_wdata_next = req_wdata;
          end
          off_next = req_addr[OFF_W-1:0];
          n_next = req_n;
          split_next = ({1'b0, req_addr[OFF_W-1:0]} + req_n) > LANE_COUNT;
          accesses_next = accesses_next + 32'h1;
        end
      end
      ST_FIRST, ST_SECOND:
      begin
        if (bus_done)
        begin
          acc_next = gathered;
          if (state_reg == ST_FIRST && split_reg)
          begin
            // Write data is left alone so both halves match
            state_next = ST_SECOND;
            bus_addr_next = {bus_addr_reg[ADDR_W-1:OFF_W] + 1'b1, {OFF_W{1'b0}}};
            bus_size_next = rem[2:0];
            splits_next = splits_next + 32'h1;
          end
          else
          begin
            state_next = ST_IDLE;
            bus_valid_next = 1'b0;
            rsp_valid_next = 1'b1;
            if (!bus_write_reg)
            begin
              rsp_rdata_next = ordered;
              rd_le_next = rd_little_endian;
            end
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        bus_valid_next = 1'b0;
      end
    endcase
    req_ready_next = (state_next == ST_IDLE) && ctrl_enable_reg;
  end

  // Sequencer registers
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      req_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 64'h0;
      bus_valid_reg <= 1'b0;
      bus_write_reg <= 1'b0;
      bus_addr_reg <= '0;
      bus_size_reg <= SIZE_DWORD;
      bus_elsize_reg <= 2'h0;
      bus_wdata_reg <= 64'h0;
      off_reg <= 3'h0;
      n_reg <= LANE_COUNT;
      split_reg <= 1'b0;
      acc_reg <= 64'h0;
      rd_le_reg <= 1'b0;
      splits_reg <= 32'h0;
      accesses_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      req_ready_reg <= req_ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_rdata_reg <= rsp_rdata_next;
      bus_valid_reg <= bus_valid_next;
      bus_write_reg <= bus_write_next;
      bus_addr_reg <= bus_addr_next;
      bus_size_reg <= bus_size_next;
      bus_elsize_reg <= bus_elsize_next;
      bus_wdata_reg <= bus_wdata_next;
      off_reg <= off_next;
      n_reg <= n_next;
      split_reg <= split_next;
      acc_reg <= acc_next;
      rd_le_reg <= rd_le_next;
      splits_reg <= splits_next;
      accesses_reg <= accesses_next;
    end
  end

  assign req_ready = req_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign bus_valid = bus_valid_reg;
  assign bus_write = bus_write_reg;
  assign bus_addr = bus_addr_reg;
  assign transfer_size_code = bus_size_reg;
  assign bus_elsize = bus_elsize_reg;
  assign bus_wdata = bus_wdata_reg;

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_write;
  logic [7:0] wr_word;
  logic [7:0] rd_word;

  // Address and data may arrive in either order; the write fires once both are held
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_enable_next = ctrl_enable_reg;
    cnt_clr_splits = 1'b0;
    cnt_clr_acc = 1'b0;
    wr_word = {awaddr_reg[7:2], 2'h0};
    if (s_axi_awvalid && awready_reg)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (wr_word == ADDR_CTRL)
      begin
        if (wstrb_reg[0])
        begin
          ctrl_enable_next = wdata_reg[CTRL_ENABLE_BIT];
        end
      end
      else if (wr_word == ADDR_SPLITS)
      begin
        cnt_clr_splits = 1'b1;
      end
      else if (wr_word == ADDR_ACCESSES)
      begin
        cnt_clr_acc = 1'b1;
      end
      else if (wr_word != ADDR_STATUS)
      begin
        bresp_next = RESP_SLVERR;
      end
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end

  // Read channel answers the cycle after the address is taken
  always_comb
  begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_word = {s_axi_araddr[7:2], 2'h0};
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && arready_reg)
    begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0;
      if (rd_word == ADDR_CTRL)
      begin
        rdata_next[CTRL_ENABLE_BIT] = ctrl_enable_reg;
      end
      else if (rd_word == ADDR_STATUS)
      begin
        rdata_next[STAT_BUSY_BIT] = state_reg != ST_IDLE;
        rdata_next[STAT_SECOND_BIT] = state_reg == ST_SECOND;
        rdata_next[STAT_RDLE_BIT] = rd_le_reg;
        rdata_next[STAT_WRLE_BIT] = wr_little_endian;
      end
      else if (rd_word == ADDR_SPLITS)
      begin
        rdata_next = splits_reg;
      end
      else if (rd_word == ADDR_ACCESSES)
      begin
        rdata_next = accesses_reg;
      end
      else
      begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  // Register slave flip-flops
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
      ctrl_enable_reg <= CTRL_ENABLE_RESET;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= (rvalid_reg || rvalid_next) ? arready_next : 1'b1;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_enable_reg <= ctrl_enable_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_first_size;
    take |=> bus_valid && transfer_size_code == $past(req_size) && bus_addr == $past(req_addr);
  endproperty
  a_first_size: assert property (p_first_size)
    else $error("first transfer size or address changed");

  property p_split_addr;
    state_reg == ST_FIRST && bus_done && split_reg
      |=> bus_valid && bus_addr[2:0] == 3'h0
      && bus_addr[ADDR_W-1:3] == $past(bus_addr[ADDR_W-1:3]) + 1'b1;
  endproperty
  a_split_addr: assert property (p_split_addr)
    else $error("second transfer not at next doubleword");

  property p_half7;
    state_reg == ST_FIRST && bus_done && n_reg == 4'h2 && off_reg == 3'h7
      |=> transfer_size_code == 3'h1 ##0 state_reg == ST_SECOND;
  endproperty
  a_half7: assert property (p_half7)
    else $error("halfword split second size wrong");

  property p_word5;
    state_reg == ST_FIRST && bus_done && n_reg == 4'h4 && off_reg == 3'h5
      |=> transfer_size_code == 3'h1;
  endproperty
  a_word5: assert property (p_word5)
    else $error("word split at five second size wrong");

  property p_dword;
    state_reg == ST_FIRST && bus_done && n_reg == 4'h8 && off_reg != 3'h0
      |=> transfer_size_code == $past(off_reg);
  endproperty
  a_dword: assert property (p_dword)
    else $error("doubleword split second size wrong");

  property p_word7_write;
    state_reg == ST_FIRST && bus_done && bus_write && n_reg == 4'h4 && off_reg == 3'h7
      |-> transfer_size_code == SIZE_WORD ##1 transfer_size_code == 3'h3;
  endproperty
  a_word7_write: assert property (p_word7_write)
    else $error("word write split sizes wrong");

  property p_wdata_same;
    state_reg == ST_SECOND |-> $stable(bus_wdata);
  endproperty
  a_wdata_same: assert property (p_wdata_same)
    else $error("write data changed between halves");

  property p_wdata_byte;
    take && req_write && req_size == SIZE_BYTE |=> bus_wdata[7:0] == $past(req_wdata[7:0]);
  endproperty
  a_wdata_byte: assert property (p_wdata_byte)
    else $error("byte write not on lane seven");

  property p_elsize;
    take |=> bus_elsize == $past(req_elsize);
  endproperty
  a_elsize: assert property (p_elsize)
    else $error("element size not carried");

  property p_read_lane;
    state_reg == ST_FIRST && bus_done && !split_reg && !bus_write && n_reg == 4'h1
      |=> rsp_valid && rsp_rdata[7:0] == $past(lane_byte);
  endproperty
  a_read_lane: assert property (p_read_lane)
    else $error("byte read from wrong lane");

  c_split_read: cover property (state_reg == ST_SECOND && bus_done && !bus_write);
  c_split_write: cover property (state_reg == ST_SECOND && bus_done && bus_write);
  c_le_read: cover property (rsp_valid && rd_le_reg);
  c_reg_write: cover property (do_write && wr_word == ADDR_CTRL);
  c_le_write: cover property (take && req_write && wr_little_endian);

endmodule : lane_steer

/* sim/mem_model.sv */
`timescale 1ns/1ps
module mem_model #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [2:0] transfer_size_code,
  input wire logic [63:0] bus_wdata,
  output logic bus_done,
  output logic [63:0] bus_rdata
);
  logic [7:0] mem [int];

  // Unwritten bytes read as a pattern of their address
  function automatic logic [7:0] peek(input int a);
    peek = mem.exists(a) ? mem[a] : (a[7:0] ^ 8'ha5);
  endfunction : peek

  // ----------------------------------------
  // Memory side of the bus
  // ----------------------------------------
  // Random pace, so both prompt and stalled answers occur
  always @(posedge clock)
  begin : serve
    int base;
    int off;
    int n;
    int cnt;
    logic go;
    logic [63:0] rd;
    rd = {$urandom, $urandom}; // Fresh junk: idle lines never repeat old data
    go = nrst && bus_valid && !bus_done && ($urandom % 3 != 0);
    if (go)
    begin
      base = int'({bus_addr[ADDR_W-1:3], 3'h0});
      off = int'(bus_addr[2:0]);
      n = (transfer_size_code == 3'h0) ? 8 : int'(transfer_size_code);
      cnt = (off + n > 8) ? 8 - off : n;
      for (int j = 0; j < cnt; j++)
      begin
        if (bus_write)
          mem[base+off+j] = bus_wdata[8*(n-1-j) +: 8];
        else
          rd[8*(7-off-j) +: 8] = peek(base + off + j);
      end
    end
    // One update per edge, so the done strobe never glitches
    bus_done <= go;
    bus_rdata <= rd;
  end

endmodule : mem_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import lane_steer_pkg::*;

  typedef struct {
    logic [31:0] a;
    logic [2:0] s;
    logic [2:0] k;
    logic [63:0] d;
  } xfer_s;

  logic clock = 1'b0;
  logic nrst, req_valid, req_ready, req_write, rsp_valid, bus_valid, bus_write, bus_done;
  logic [31:0] req_addr, bus_addr;
  logic [2:0] req_size, transfer_size_code;
  logic [1:0] req_elsize, bus_elsize;
  logic [63:0] req_wdata, rsp_rdata, bus_wdata, bus_rdata;
  logic rd_little_endian, wr_little_endian;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] sz_tab [4] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_DWORD};
  logic [7:0] ref_mem [int];
  xfer_s exp_q [$];
  int err_total, total_checks, n_acc, n_split;
  logic last_rle;

  always #5 clock = ~clock;

  lane_steer u_lane_steer (.clock, .nrst, .req_valid, .req_ready, .req_write, .req_addr,
    .req_size, .req_elsize, .req_wdata, .rsp_valid, .rsp_rdata, .bus_valid, .bus_write,
    .bus_addr, .transfer_size_code, .bus_elsize, .bus_wdata, .bus_done, .bus_rdata,
    .rd_little_endian, .wr_little_endian, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  mem_model u_mem_model (.clock, .nrst, .bus_valid, .bus_write, .bus_addr,
    .transfer_size_code, .bus_wdata, .bus_done, .bus_rdata);

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk_val(input string what, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    chk_val(what, 64'(e), 64'(g));
  endtask : chk_resp

  task automatic tmo(input string what);
    err_total++;
    $display("[FAIL] %s expected answer seen timeout", what);
    results();
  endtask : tmo

  function automatic logic [7:0] rdb(input int a);
    rdb = ref_mem.exists(a) ? ref_mem[a] : (a[7:0] ^ 8'ha5);
  endfunction : rdb

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rr);
    int k;
    @(posedge clock); // Lets the previous call's release land first
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && k < 100);
    if (k >= 100) tmo("write response");
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    int k;
    @(posedge clock); // Lets the previous call's release land first
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && k < 100);
    if (k >= 100) tmo("read data");
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // ----------------------------------------
  // Core access with reference model
  // ----------------------------------------
  task automatic access(input logic w, input logic [31:0] a, input logic [2:0] sz,
                        input logic rle);
    int n;
    int off;
    int k;
    logic [63:0] d;
    logic [63:0] e;
    xfer_s x;
    n = (sz == SIZE_DWORD) ? 8 : int'(sz);
    off = int'(a[2:0]);
    d = {$urandom, $urandom};
    if (n < 8) d = d & ((64'h1 << (8 * n)) - 64'h1); // Right-justified value
    e = d;
    // Little-endian stores reach the bus byte-reversed within the value
    for (k = 0; k < n; k++)
      if (wr_little_endian) e[8*k +: 8] = d[8*(n-1-k) +: 8];
    x = '{a, sz, {w, 2'($urandom)}, e};
    exp_q.push_back(x);
    n_acc++;
    if (off + n > 8)
    begin
      x.a = {a[31:3] + 29'h1, 3'h0};
      x.s = 3'(off + n - 8);
      exp_q.push_back(x);
      n_split++;
    end
    e = 64'h0;
    for (k = 0; k < n; k++)
    begin
      if (w) ref_mem[int'(a)+k] = x.d[8*(n-1-k) +: 8];
      else if (rle) e = e | (64'(rdb(int'(a) + k)) << (8 * k));
      else e = (e << 8) | 64'(rdb(int'(a) + k));
    end
    if (!w) last_rle = rle;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_size <= sz;
    req_elsize <= x.k[1:0];
    req_wdata <= d;
    rd_little_endian <= rle;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (req_ready !== 1'b1 && k < 200);
    if (k >= 200) tmo("request take");
    req_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (rsp_valid !== 1'b1 && k < 200);
    if (k >= 200) tmo("access end");
    if (!w) chk_val("read data", e, rsp_rdata);
  endtask : access

  // Every finished bus transfer against the reference list
  always @(posedge clock)
  begin : watch
    xfer_s x;
    if (nrst && bus_valid && bus_done)
    begin
      if (exp_q.size() == 0)
        chk_val("spare transfer", 64'h0, 64'h1);
      else
      begin
        x = exp_q.pop_front();
        chk_val("bus addr", 64'(x.a), 64'(bus_addr));
        chk_val("bus size", 64'(x.s), 64'(transfer_size_code));
        chk_val("bus kind", 64'(x.k), 64'({bus_write, bus_elsize}));
        if (x.k[2]) chk_val("bus wdata", x.d, bus_wdata);
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(46));
    {nrst, req_valid, req_write, req_elsize, rd_little_endian} = '0;
    {req_addr, req_size, req_wdata} = '0;
    wr_little_endian = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    last_rle = 1'b0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    axi_rd(ADDR_CTRL, r, rs);
    chk_val("ctrl reset", 64'(CTRL_ENABLE_RESET), 64'(r[CTRL_ENABLE_BIT]));
    // Disabled core port must refuse requests
    axi_wr(ADDR_CTRL, 32'h0, rs);
    repeat (3) @(posedge clock);
    chk_val("ready while off", 64'h0, 64'(req_ready));
    axi_wr(ADDR_CTRL, 32'h1, rs);
    // Every offset and size, a store then a load, each at its own random doubleword
    for (int off = 0; off < 8; off++)
      for (int si = 0; si < 4; si++)
        for (int w = 1; w >= 0; w--)
          access(w[0], 32'h40 + 32'(8 * ($urandom % 4) + off), sz_tab[si], 1'($urandom));
    repeat (40) access(1'($urandom), 32'($urandom % 64), sz_tab[$urandom % 4], 1'($urandom));
    // Little-endian stores at every offset, each read back at once
    wr_little_endian <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 16; i++)
      access(!i[0], 32'h80 + 32'(9 * (i / 2)), sz_tab[(i / 2) % 4], 1'($urandom));
    wr_little_endian <= 1'b0;
    axi_rd(ADDR_ACCESSES, r, rs);
    chk_val("access count", 64'(n_acc), 64'(r));
    axi_rd(ADDR_SPLITS, r, rs);
    chk_val("split count", 64'(n_split), 64'(r));
    axi_rd(ADDR_STATUS, r, rs);
    chk_val("status", 64'({1'b0, last_rle, 2'h0}), 64'(r[3:0]));
    axi_wr(ADDR_STATUS, 32'hf, rs);
    chk_resp("status write", RESP_OKAY, rs);
    axi_rd(8'h10, r, rs);
    chk_resp("unmapped read", RESP_SLVERR, rs);
    chk_val("unmapped data", 64'h0, 64'(r));
    axi_wr(8'h10, 32'h1, rs);
    chk_resp("unmapped write", RESP_SLVERR, rs);
    chk_val("left over", 64'h0, 64'(exp_q.size()));
    results();
  end

endmodule : tb
